// ==== fqm_map.svh ====
// Register indices, reset values and internal defaults of the quality monitor
// Overview of operation
// [RULE1] Report six-bit signalling word length
// [RULE2] Priority bit reads HP unless hierarchical
// [RULE3] Channel restart clears count, flag, restarts
// [RULE4] Writable 24-bit channel period, reset 0186A0h
// [RULE5] Channel bit error count latched per period
// [RULE6] Channel ready flag after period bits counted
// [RULE7] Host waits for ready before reading result
// [RULE8] Read-only packet sync lock status bit
// [RULE9] Report inversion found and applied at lock
// [RULE10] Hold-lock bit keeps sync locked forever; the code holds lock only while the bit stays set
// [RULE11] Lock after N good correlations, zero means 4
// [RULE12] Unlock after N bad correlations, zero means 5
// [RULE13] Flip inversion after N trials, zero means 40
// [RULE14] Auto mode default; manual drives manual bit
// [RULE15] Bypass bit bypasses outer decoder, default off
// [RULE16] Uncorrectable restart clears counter, self-returns
// [RULE17] Eight-bit uncorrectable counter saturates at 255
// [RULE18] Post-decoding restart clears count, flag, restarts
// [RULE19] 16-bit packet period lengths reset to FFFFh
// [RULE20] Post-decoding bit errors counted in 24 bits
// [RULE21] Bit error ready flag after period packets
// [RULE22] Packet error count, restart and ready flag
// [RULE23] Restart bits read zero soon; zero ignored
`ifndef FQM_MAP_SVH
`define FQM_MAP_SVH
`define FQM_IDX_SIG_LEN 11'h418
`define FQM_IDX_HH_IL 11'h41c
`define FQM_IDX_PRIO 11'h420
`define FQM_IDX_CHAN_RST 11'h424
`define FQM_IDX_CHAN_PER 11'h428
`define FQM_IDX_CHAN_CNT 11'h430
`define FQM_IDX_CHAN_RDY 11'h434
`define FQM_IDX_LOCKED 11'h440
`define FQM_IDX_INV_FOUND 11'h444
`define FQM_IDX_HOLD 11'h448
`define FQM_IDX_LOCK_THR 11'h44d
`define FQM_IDX_UNLOCK_THR 11'h44e
`define FQM_IDX_TRIALS 11'h44f
`define FQM_IDX_INV_CTRL 11'h450
`define FQM_IDX_BYPASS 11'h461
`define FQM_IDX_UNC_RST 11'h464
`define FQM_IDX_UNC_CNT 11'h468
`define FQM_IDX_POST_RST 11'h46c
`define FQM_IDX_POST_PER 11'h470
`define FQM_IDX_POST_CNT 11'h478
`define FQM_IDX_POST_RDY 11'h47c
`define FQM_IDX_PKT_RST 11'h480
`define FQM_IDX_PKT_PER 11'h484
`define FQM_IDX_PKT_CNT 11'h48c
`define FQM_IDX_PKT_RDY 11'h490
`define FQM_IDX_DEINT 11'h4c0
`define FQM_IDX_HP_FEC 11'h417
`define FQM_RST_CHAN_PER 24'h0186a0
`define FQM_RST_PKT_PER 16'hffff
`define FQM_RST_INV_CTRL 2'h1
`define FQM_BIT_INV_AUTO 0
`define FQM_BIT_INV_MANUAL 1
`define FQM_DEF_LOCK_THR 4'h4
`define FQM_DEF_UNLOCK_THR 8'h05
`define FQM_DEF_TRIALS 8'h28
`define FQM_UNC_MAX 8'hff
`endif

// ==== fqm_monitor.sv ====
// Quality monitor top: APB register file, uncorrectable counter, windows, sync
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "fqm_map.svh"
module fqm_monitor #(
   parameter int ADDR_W = 13
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire fqm_pkg::fqm_status_s status,
   input wire fqm_pkg::fqm_events_s events,
   output logic outer_decoder_bypass,
   output logic inversion_ctrl,
   output logic pkt_sync_locked
);
   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic [5:0] sig_len;
      logic hh_il;
      logic prio;
      logic hp_fec;
      logic deint;
      logic chan_rst;
      logic post_rst;
      logic pkt_rst;
      logic unc_rst;
      logic [23:0] chan_per;
      logic [15:0] post_per;
      logic [15:0] pkt_per;
      logic hold;
      logic [3:0] lock_thr;
      logic [7:0] unlock_thr;
      logic [7:0] trials;
      logic [1:0] inv_cfg;
      logic bypass;
      logic [7:0] unc;
   } fqm_top_s;

   fqm_top_s s_r, s_nxt;
   logic [10:0] idx;
   logic [31:0] rdata;
   logic hit;
   logic wr;
   logic [23:0] chan_cnt;
   logic chan_rdy;
   logic [23:0] post_cnt;
   logic post_rdy;
   logic [15:0] pkt_cnt;
   logic pkt_rdy;
   logic locked;
   logic inv_found;
   logic inv_ctrl;

   if (ADDR_W < 13) begin : g_bad_addr_w
      $error("fqm_monitor: ADDR_W too small for map");
   end

   // Word index; every printed offset sits at four times its value
   assign idx = paddr[12:2];

   always_comb begin
      hit = 1'b1;
      rdata = '0;
      unique case (idx)
         `FQM_IDX_SIG_LEN: rdata = {26'h0, s_r.sig_len}; // [RULE1]
         `FQM_IDX_HH_IL: rdata = {31'h0, s_r.hh_il};
         `FQM_IDX_PRIO: rdata = {31'h0, s_r.prio}; // [RULE2]
         `FQM_IDX_HP_FEC: rdata = {31'h0, s_r.hp_fec};
         `FQM_IDX_DEINT: rdata = {31'h0, s_r.deint};
         `FQM_IDX_CHAN_RST: rdata = {31'h0, s_r.chan_rst}; // [RULE23]
         `FQM_IDX_CHAN_PER: rdata = {8'h0, s_r.chan_per};
         `FQM_IDX_CHAN_CNT: rdata = {8'h0, chan_cnt};
         `FQM_IDX_CHAN_RDY: rdata = {31'h0, chan_rdy};
         `FQM_IDX_LOCKED: rdata = {31'h0, locked}; // [RULE8]
         `FQM_IDX_INV_FOUND: rdata = {31'h0, inv_found}; // [RULE9]
         `FQM_IDX_HOLD: rdata = {31'h0, s_r.hold};
         `FQM_IDX_LOCK_THR: rdata = {28'h0, s_r.lock_thr};
         `FQM_IDX_UNLOCK_THR: rdata = {24'h0, s_r.unlock_thr};
         `FQM_IDX_TRIALS: rdata = {24'h0, s_r.trials};
         `FQM_IDX_INV_CTRL: rdata = {30'h0, s_r.inv_cfg};
         `FQM_IDX_BYPASS: rdata = {31'h0, s_r.bypass};
         `FQM_IDX_UNC_RST: rdata = {31'h0, s_r.unc_rst};
         `FQM_IDX_UNC_CNT: rdata = {24'h0, s_r.unc};
         `FQM_IDX_POST_RST: rdata = {31'h0, s_r.post_rst};
         `FQM_IDX_POST_PER: rdata = {16'h0, s_r.post_per};
         `FQM_IDX_POST_CNT: rdata = {8'h0, post_cnt};
         `FQM_IDX_POST_RDY: rdata = {31'h0, post_rdy};
         `FQM_IDX_PKT_RST: rdata = {31'h0, s_r.pkt_rst};
         `FQM_IDX_PKT_PER: rdata = {16'h0, s_r.pkt_per};
         `FQM_IDX_PKT_CNT: rdata = {16'h0, pkt_cnt};
         `FQM_IDX_PKT_RDY: rdata = {31'h0, pkt_rdy};
         default: hit = 1'b0;
      endcase
      // Shift, not a slice: a slice above bit 12 is empty at the default width
      if ((paddr >> 13) != '0) hit = 1'b0;
   end

   always_comb begin
      s_nxt = s_r;
      // Zero-wait slave: ready in the first access cycle only
      s_nxt.pready = psel && !penable && !s_r.pready;
      s_nxt.prdata = (psel && !penable && !pwrite && hit) ? rdata : 32'h0;
      s_nxt.pslverr = psel && !penable && !hit;
      wr = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
      s_nxt.sig_len = status.sig_len; // [RULE1]
      s_nxt.hh_il = status.hh_interleave;
      s_nxt.prio = status.hierarchical && status.lp_selected; // [RULE2]
      s_nxt.hp_fec = status.hp_fec;
      s_nxt.deint = status.symb_deint;
      // Restart bits live for one cycle: a read set up right after the write sees one, any later read zero
      s_nxt.chan_rst = 1'b0;
      s_nxt.post_rst = 1'b0;
      s_nxt.pkt_rst = 1'b0;
      s_nxt.unc_rst = 1'b0;
      if (wr) begin
         unique case (idx)
            `FQM_IDX_CHAN_RST: s_nxt.chan_rst = pwdata[0]; // [RULE3] [RULE23]
            `FQM_IDX_POST_RST: s_nxt.post_rst = pwdata[0]; // [RULE18] [RULE23]
            `FQM_IDX_PKT_RST: s_nxt.pkt_rst = pwdata[0]; // [RULE22] [RULE23]
            `FQM_IDX_UNC_RST: s_nxt.unc_rst = pwdata[0]; // [RULE16] [RULE23]
            `FQM_IDX_CHAN_PER: s_nxt.chan_per = pwdata[23:0]; // [RULE4]
            `FQM_IDX_POST_PER: s_nxt.post_per = pwdata[15:0]; // [RULE19]
            `FQM_IDX_PKT_PER: s_nxt.pkt_per = pwdata[15:0]; // [RULE19]
            `FQM_IDX_HOLD: s_nxt.hold = pwdata[0]; // [RULE10]
            `FQM_IDX_LOCK_THR: s_nxt.lock_thr = pwdata[3:0];
            `FQM_IDX_UNLOCK_THR: s_nxt.unlock_thr = pwdata[7:0];
            `FQM_IDX_TRIALS: s_nxt.trials = pwdata[7:0];
            `FQM_IDX_INV_CTRL: s_nxt.inv_cfg = pwdata[1:0]; // [RULE14]
            `FQM_IDX_BYPASS: s_nxt.bypass = pwdata[0]; // [RULE15]
            default: begin
            end
         endcase
      end
      // A packet arriving with the restart counts into the new interval
      if (s_r.unc_rst) begin
         s_nxt.unc = {7'h0, events.pkt_valid && events.pkt_uncorrectable}; // [RULE16]
      end else if (events.pkt_valid && events.pkt_uncorrectable && s_r.unc != `FQM_UNC_MAX) begin
         s_nxt.unc = s_r.unc + 8'h01; // [RULE17]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{chan_per: `FQM_RST_CHAN_PER, post_per: `FQM_RST_PKT_PER,
                  pkt_per: `FQM_RST_PKT_PER, inv_cfg: `FQM_RST_INV_CTRL, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign outer_decoder_bypass = s_r.bypass; // [RULE15]
   assign inversion_ctrl = inv_ctrl;
   assign pkt_sync_locked = locked;

   fqm_window #(.CNT_W(24), .PER_W(24), .ADD_W(1)) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .restart(s_r.chan_rst),
      .period(s_r.chan_per),
      .tick(events.chan_valid),
      .add(events.chan_err),
      .result(chan_cnt),
      .avail(chan_rdy)
   );

   fqm_window #(.CNT_W(24), .PER_W(16), .ADD_W(11)) u_post (
      .pclk(pclk),
      .presetn(presetn),
      .restart(s_r.post_rst),
      .period(s_r.post_per),
      .tick(events.pkt_valid),
      .add(events.pkt_bit_errs),
      .result(post_cnt),
      .avail(post_rdy)
   );

   fqm_window #(.CNT_W(16), .PER_W(16), .ADD_W(1)) u_pkt (
      .pclk(pclk),
      .presetn(presetn),
      .restart(s_r.pkt_rst),
      .period(s_r.pkt_per),
      .tick(events.pkt_valid),
      .add(events.pkt_uncorrectable),
      .result(pkt_cnt),
      .avail(pkt_rdy)
   );

   fqm_pkt_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .corr_valid(events.corr_valid),
      .corr_ok(events.corr_ok),
      .hold_lock(s_r.hold),
      .lock_thr(s_r.lock_thr),
      .unlock_thr(s_r.unlock_thr),
      .trials(s_r.trials),
      .inv_auto(s_r.inv_cfg[`FQM_BIT_INV_AUTO]),
      .inv_manual(s_r.inv_cfg[`FQM_BIT_INV_MANUAL]),
      .locked(locked),
      .inv_found(inv_found),
      .inv_ctrl(inv_ctrl)
   );

   AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !s_r.pready |=> s_r.pready ##1 !s_r.pready || (psel && !penable))
      else $error("ready not one cycle after setup");
   AST_PRIO_HP: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
      !status.hierarchical |=> !s_r.prio) else $error("priority not HP");
   // A period ending with the restart pulse legally keeps ready high
   AST_RESTART_SELF: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
      s_r.chan_rst && !events.chan_valid |=> !s_r.chan_rst && !chan_rdy)
      else $error("restart bit stuck");
   AST_CHAN_RESTART: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      $rose(s_r.chan_rst) && !events.chan_valid |=> chan_cnt == 24'h0)
      else $error("channel count not cleared");
   AST_UNC_SAT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
      s_r.unc == `FQM_UNC_MAX && !s_r.unc_rst |=> s_r.unc == `FQM_UNC_MAX)
      else $error("uncorrectable count wrapped");
   AST_UNC_INC: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
      events.pkt_valid && events.pkt_uncorrectable && !s_r.unc_rst && s_r.unc < 8'hfe
      |=> s_r.unc == $past(s_r.unc) + 8'h01) else $error("uncorrectable not counted");
   AST_UNC_CLR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
      s_r.unc_rst && !events.pkt_valid |=> s_r.unc == 8'h00)
      else $error("uncorrectable not cleared");
   AST_HOLD_LOCK: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
      locked && s_r.hold |=> locked) else $error("held lock dropped");
   AST_MANUAL_INV: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
      !s_r.inv_cfg[`FQM_BIT_INV_AUTO] |=> inv_ctrl == $past(s_r.inv_cfg[`FQM_BIT_INV_MANUAL]))
      else $error("manual inversion not applied");
   AST_WR_BYPASS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
      psel && penable && s_r.pready && pwrite && idx == `FQM_IDX_BYPASS && !s_r.pslverr
      |=> outer_decoder_bypass == $past(pwdata[0])) else $error("bypass write lost");

   COV_LOCK: cover property (@(posedge pclk) disable iff (!presetn) $rose(locked));
   COV_CHAN_RDY: cover property (@(posedge pclk) disable iff (!presetn) $rose(chan_rdy));
   COV_UNC_SAT: cover property (@(posedge pclk) disable iff (!presetn) s_r.unc == `FQM_UNC_MAX);
   COV_PKT_RDY: cover property (@(posedge pclk) disable iff (!presetn) $rose(pkt_rdy));
endmodule : fqm_monitor

// ==== fqm_pkg.sv ====
// Types shared by the quality monitor modules
package fqm_pkg;
   typedef enum logic {FQM_SEARCH, FQM_SUPERVISE} fqm_sync_e;
   typedef struct packed {
      logic [5:0] sig_len;
      logic hh_interleave;
      logic hierarchical;
      logic lp_selected;
      logic hp_fec;
      logic symb_deint;
   } fqm_status_s;
   typedef struct packed {
      logic chan_valid;
      logic chan_err;
      logic pkt_valid;
      logic [10:0] pkt_bit_errs;
      logic pkt_uncorrectable;
      logic corr_valid;
      logic corr_ok;
   } fqm_events_s;
   typedef struct packed {
      fqm_sync_e st;
      logic [3:0] good;
      logic [7:0] bad;
      logic [7:0] trial;
      logic inv;
      logic found;
      logic ctrl;
      logic locked;
   } fqm_sync_s;
endpackage : fqm_pkg

// ==== fqm_pkt_sync.sv ====
// Packet synchronisation state machine with inversion search
`timescale 1ns/1ps
`include "fqm_map.svh"
module fqm_pkt_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic corr_valid,
   input wire logic corr_ok,
   input wire logic hold_lock,
   input wire logic [3:0] lock_thr,
   input wire logic [7:0] unlock_thr,
   input wire logic [7:0] trials,
   input wire logic inv_auto,
   input wire logic inv_manual,
   output logic locked,
   output logic inv_found,
   output logic inv_ctrl
);
   fqm_pkg::fqm_sync_s s_r, s_nxt;
   logic [3:0] lock_n;
   logic [7:0] unlock_n;
   logic [7:0] trials_n;

   always_comb begin
      s_nxt = s_r;
      lock_n = (lock_thr == 4'h0) ? `FQM_DEF_LOCK_THR : lock_thr; // [RULE11]
      unlock_n = (unlock_thr == 8'h00) ? `FQM_DEF_UNLOCK_THR : unlock_thr; // [RULE12]
      trials_n = (trials == 8'h00) ? `FQM_DEF_TRIALS : trials; // [RULE13]
      unique case (s_r.st)
         fqm_pkg::FQM_SEARCH: begin
            if (corr_valid) begin
               if (corr_ok && ({1'b0, s_r.good} + 5'h01 >= {1'b0, lock_n})) begin
                  s_nxt.st = fqm_pkg::FQM_SUPERVISE; // [RULE11]
                  s_nxt.good = '0;
                  s_nxt.bad = '0;
                  s_nxt.trial = '0;
                  s_nxt.found = s_r.ctrl; // [RULE9]
               end else begin
                  s_nxt.good = corr_ok ? s_r.good + 4'h1 : 4'h0;
                  if ({1'b0, s_r.trial} + 9'h001 >= {1'b0, trials_n}) begin
                     s_nxt.trial = '0;
                     s_nxt.good = '0;
                     if (inv_auto) s_nxt.inv = ~s_r.inv; // [RULE13]
                  end else begin
                     s_nxt.trial = s_r.trial + 8'h01;
                  end
               end
            end
         end
         fqm_pkg::FQM_SUPERVISE: begin
            if (corr_valid) begin
               if (corr_ok) begin
                  s_nxt.bad = '0;
               end else if (!hold_lock && ({1'b0, s_r.bad} + 9'h001 >= {1'b0, unlock_n})) begin
                  s_nxt.st = fqm_pkg::FQM_SEARCH; // [RULE12]
                  s_nxt.bad = '0;
                  s_nxt.good = '0;
               end else if (s_r.bad != 8'hff) begin
                  // Held lock keeps counting but never unlocks
                  s_nxt.bad = s_r.bad + 8'h01; // [RULE10]
               end
            end
         end
      endcase
      s_nxt.locked = (s_nxt.st == fqm_pkg::FQM_SUPERVISE); // [RULE8]
      s_nxt.ctrl = inv_auto ? s_nxt.inv : inv_manual; // [RULE14]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{st: fqm_pkg::FQM_SEARCH, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign locked = s_r.locked;
   assign inv_found = s_r.found;
   assign inv_ctrl = s_r.ctrl;

   AST_SYNC_LOCK_CAUSE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
      $rose(s_r.locked) |-> $past(corr_valid && corr_ok)) else $error("lock without good corr");
   AST_SYNC_UNLOCK_CAUSE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
      $fell(s_r.locked) |-> $past(!hold_lock && corr_valid && !corr_ok))
      else $error("unlock without bad corr");
   COV_SYNC_FLIP: cover property (@(posedge pclk) disable iff (!presetn) $changed(s_r.inv));
endmodule : fqm_pkt_sync

// ==== fqm_window.sv ====
// Windowed error accumulator with latched result and ready flag
`timescale 1ns/1ps
module fqm_window #(
   parameter int CNT_W = 24,
   parameter int PER_W = 24,
   parameter int ADD_W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   input wire logic [PER_W-1:0] period,
   input wire logic tick,
   input wire logic [ADD_W-1:0] add,
   output logic [CNT_W-1:0] result,
   output logic avail
);
   typedef struct packed {
      logic [PER_W-1:0] ticks;
      logic [CNT_W-1:0] acc;
      logic [CNT_W-1:0] result;
      logic avail;
   } fqm_win_s;
   fqm_win_s s_r, s_nxt;
   logic [CNT_W:0] sum;
   logic [PER_W:0] next_ticks;
   logic done;

   // Refused at elaboration: the adder and tick counter cannot serve these widths
   if (ADD_W > CNT_W || PER_W < 1) begin : g_bad_widths
      $error("fqm_window: bad widths");
   end

   always_comb begin
      s_nxt = s_r;
      sum = {1'b0, s_r.acc} + {{(CNT_W + 1 - ADD_W){1'b0}}, add};
      next_ticks = {1'b0, s_r.ticks} + {{PER_W{1'b0}}, 1'b1};
      done = tick && (next_ticks >= {1'b0, period});
      if (restart) begin
         // Old period's end still latches; the set beats the clear
         s_nxt.acc = '0;
         s_nxt.ticks = '0;
         s_nxt.result = '0;
         s_nxt.avail = 1'b0;
      end else if (tick) begin
         // Saturate rather than wrap on extreme error loads
         s_nxt.acc = sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0];
         s_nxt.ticks = next_ticks[PER_W-1:0];
      end
      if (done) begin
         s_nxt.result = sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0]; // [RULE5] [RULE20] [RULE22]
         s_nxt.avail = 1'b1; // [RULE6] [RULE21] [RULE22]
         s_nxt.acc = '0;
         s_nxt.ticks = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign result = s_r.result;
   assign avail = s_r.avail;

   AST_WIN_AVAIL_CAUSE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
      $rose(s_r.avail) |-> $past(tick)) else $error("ready rose without a tick");
   AST_WIN_RESTART_CLR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      restart && !tick |=> !s_r.avail && s_r.result == '0)
      else $error("restart did not clear window");
endmodule : fqm_window

// ==== test_fqm_monitor.sv ====
// Register-level testbench of the quality monitor over APB
`timescale 1ns/1ps
`include "fqm_map.svh"
module test_fqm_monitor;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [12:0] paddr = 13'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   fqm_pkg::fqm_status_s status = '0;
   fqm_pkg::fqm_events_s events = '0;
   fqm_pkg::fqm_events_s ev_u;
   logic outer_decoder_bypass;
   logic inversion_ctrl;
   logic pkt_sync_locked;
   int n_fail = 0;
   int comparisons = 0;
   logic [31:0] rd_v;
   logic err_v;
   logic [5:0] lens [3] = '{6'h21, 6'h1f, 6'h17};

   always #5 pclk = ~pclk;

   fqm_monitor i_fqm_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .status(status), .events(events),
      .outer_decoder_bypass(outer_decoder_bypass), .inversion_ctrl(inversion_ctrl),
      .pkt_sync_locked(pkt_sync_locked));

   task results;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Holds the request until pready is seen; bounded so a dead slave ends the run
   task apb(input logic wr, input logic [10:0] idx, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         n_fail++;
         results();
      end
   endtask : apb

   task wr(input logic [10:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask : wr

   task rdchk(input string name, input logic [10:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h00000000);
      chk(name, rd_v, exp);
   endtask : rdchk

   // One-cycle strobes with a gap; two spare edges let registered outputs settle
   task ev(input fqm_pkg::fqm_events_s e, input int n);
      repeat (n) begin
         @(posedge pclk);
         events <= e;
         @(posedge pclk);
         events <= '0;
      end
      repeat (2) @(posedge pclk);
   endtask : ev

   task corr(input logic ok, input int n);
      fqm_pkg::fqm_events_s e;
      e = '0;
      e.corr_valid = 1'b1;
      e.corr_ok = ok;
      ev(e, n);
   endtask : corr

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("chan period", `FQM_IDX_CHAN_PER, 32'h000186a0);
      rdchk("post period", `FQM_IDX_POST_PER, 32'h0000ffff);
      rdchk("pkt period", `FQM_IDX_PKT_PER, 32'h0000ffff);
      rdchk("inv ctrl reg", `FQM_IDX_INV_CTRL, 32'h00000001);
      rdchk("bypass reg", `FQM_IDX_BYPASS, 32'h00000000);
      rdchk("locked reg", `FQM_IDX_LOCKED, 32'h00000000);
      chk("bypass pin", {31'h0, outer_decoder_bypass}, 32'h00000000);
      chk("inversion pin", {31'h0, inversion_ctrl}, 32'h00000000);
      chk("locked pin", {31'h0, pkt_sync_locked}, 32'h00000000);
      $display("test reset done");
      for (int k = 0; k < 3; k++) begin
         status.sig_len <= lens[k];
         rdchk("word length", `FQM_IDX_SIG_LEN, {26'h0, lens[k]});
      end
      status.hierarchical <= 1'b1;
      status.lp_selected <= 1'b1;
      rdchk("priority hier", `FQM_IDX_PRIO, 32'h00000001);
      status.lp_selected <= 1'b0;
      rdchk("priority hier hp", `FQM_IDX_PRIO, 32'h00000000);
      status.hierarchical <= 1'b0;
      status.lp_selected <= 1'b1;
      rdchk("priority flat", `FQM_IDX_PRIO, 32'h00000000);
      status.hh_interleave <= 1'b1;
      status.hp_fec <= 1'b1;
      status.symb_deint <= 1'b1;
      rdchk("interleaver", `FQM_IDX_HH_IL, 32'h00000001);
      rdchk("hp fec", `FQM_IDX_HP_FEC, 32'h00000001);
      rdchk("deinterleave", `FQM_IDX_DEINT, 32'h00000001);
      wr(`FQM_IDX_BYPASS, 32'h00000001);
      rdchk("bypass reg", `FQM_IDX_BYPASS, 32'h00000001);
      chk("bypass pin", {31'h0, outer_decoder_bypass}, 32'h00000001);
      apb(1'b0, 11'h7ff, 32'h00000000);
      chk("unmapped err", {31'h0, err_v}, 32'h00000001);
      chk("unmapped data", rd_v, 32'h00000000);
      $display("test status done");
      wr(`FQM_IDX_CHAN_PER, 32'h00000003);
      wr(`FQM_IDX_CHAN_RST, 32'h00000001);
      rdchk("chan restart", `FQM_IDX_CHAN_RST, 32'h00000000);
      rdchk("chan ready", `FQM_IDX_CHAN_RDY, 32'h00000000);
      ev_u = '0;
      ev_u.chan_valid = 1'b1;
      ev_u.chan_err = 1'b1;
      ev(ev_u, 2);
      ev_u.chan_err = 1'b0;
      ev(ev_u, 1);
      // Count is only read once the ready flag is up
      rdchk("chan ready", `FQM_IDX_CHAN_RDY, 32'h00000001);
      rdchk("chan count", `FQM_IDX_CHAN_CNT, 32'h00000002);
      wr(`FQM_IDX_CHAN_RST, 32'h00000000);
      rdchk("chan ready", `FQM_IDX_CHAN_RDY, 32'h00000001);
      wr(`FQM_IDX_CHAN_RST, 32'h00000001);
      rdchk("chan ready", `FQM_IDX_CHAN_RDY, 32'h00000000);
      rdchk("chan count", `FQM_IDX_CHAN_CNT, 32'h00000000);
      $display("test channel window done");
      ev_u = '0;
      ev_u.pkt_valid = 1'b1;
      ev_u.pkt_uncorrectable = 1'b1;
      ev(ev_u, 2);
      rdchk("uncor count", `FQM_IDX_UNC_CNT, 32'h00000002);
      ev(ev_u, 258);
      rdchk("uncor count", `FQM_IDX_UNC_CNT, 32'h000000ff);
      wr(`FQM_IDX_UNC_RST, 32'h00000001);
      rdchk("uncor count", `FQM_IDX_UNC_CNT, 32'h00000000);
      rdchk("uncor restart", `FQM_IDX_UNC_RST, 32'h00000000);
      $display("test uncorrectable done");
      wr(`FQM_IDX_POST_PER, 32'h00000002);
      wr(`FQM_IDX_PKT_PER, 32'h00000002);
      wr(`FQM_IDX_POST_RST, 32'h00000001);
      wr(`FQM_IDX_PKT_RST, 32'h00000001);
      rdchk("post ready", `FQM_IDX_POST_RDY, 32'h00000000);
      rdchk("pkt ready", `FQM_IDX_PKT_RDY, 32'h00000000);
      ev_u.pkt_bit_errs = 11'h005;
      ev(ev_u, 1);
      rdchk("post ready", `FQM_IDX_POST_RDY, 32'h00000000);
      ev_u.pkt_bit_errs = 11'h007;
      ev_u.pkt_uncorrectable = 1'b0;
      ev(ev_u, 1);
      rdchk("post ready", `FQM_IDX_POST_RDY, 32'h00000001);
      rdchk("post count", `FQM_IDX_POST_CNT, 32'h0000000c);
      rdchk("pkt ready", `FQM_IDX_PKT_RDY, 32'h00000001);
      rdchk("pkt count", `FQM_IDX_PKT_CNT, 32'h00000001);
      wr(`FQM_IDX_POST_RST, 32'h00000001);
      rdchk("post ready", `FQM_IDX_POST_RDY, 32'h00000000);
      rdchk("post count", `FQM_IDX_POST_CNT, 32'h00000000);
      wr(`FQM_IDX_PKT_RST, 32'h00000001);
      rdchk("pkt ready", `FQM_IDX_PKT_RDY, 32'h00000000);
      $display("test error windows done");
      wr(`FQM_IDX_TRIALS, 32'h00000003);
      corr(1'b0, 2);
      chk("inversion pin", {31'h0, inversion_ctrl}, 32'h00000000);
      corr(1'b0, 1);
      chk("inversion pin", {31'h0, inversion_ctrl}, 32'h00000001);
      // Default trial count so the lock attempt is not cut short by a flip
      wr(`FQM_IDX_TRIALS, 32'h00000000);
      corr(1'b1, 3);
      chk("locked pin", {31'h0, pkt_sync_locked}, 32'h00000000);
      corr(1'b1, 1);
      chk("locked pin", {31'h0, pkt_sync_locked}, 32'h00000001);
      rdchk("locked reg", `FQM_IDX_LOCKED, 32'h00000001);
      rdchk("inv found", `FQM_IDX_INV_FOUND, 32'h00000001);
      corr(1'b0, 4);
      chk("locked pin", {31'h0, pkt_sync_locked}, 32'h00000001);
      corr(1'b0, 1);
      chk("locked pin", {31'h0, pkt_sync_locked}, 32'h00000000);
      wr(`FQM_IDX_HOLD, 32'h00000001);
      corr(1'b1, 4);
      corr(1'b0, 6);
      chk("held lock", {31'h0, pkt_sync_locked}, 32'h00000001);
      wr(`FQM_IDX_INV_CTRL, 32'h00000002);
      rdchk("inv ctrl reg", `FQM_IDX_INV_CTRL, 32'h00000002);
      chk("manual inv", {31'h0, inversion_ctrl}, 32'h00000001);
      wr(`FQM_IDX_INV_CTRL, 32'h00000000);
      rdchk("inv ctrl reg", `FQM_IDX_INV_CTRL, 32'h00000000);
      chk("manual inv", {31'h0, inversion_ctrl}, 32'h00000000);
      $display("test packet sync done");
      results();
   end
endmodule : test_fqm_monitor
